// ===== hw/startup_pkg.sv
// constants shared by the start-up sequencer and its voltage-code qualifier
package startup_pkg;
    // clock
    localparam int CLK_PERIOD_NS = 5;
    localparam int CLK_HZ = 200_000_000;
    // voltage-code inputs
    localparam int CODE_W = 8;
    localparam int CODE_FIVE_W = 5;
    localparam int CODE_READS = 3;
    localparam int SAMPLE_HZ = 3_000_000;
    localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
    // times, in their own unit, and the derived cycle counts
    localparam int INITIAL_DELAY_NS = 1_400_000;
    localparam int BOOT_HOLD_NS = 85_000;
    localparam int VALIDATE_NS = 500;
    localparam int GOOD_DELAY_FOUR_NS = 440_000;
    localparam int GOOD_DELAY_THREE_NS = 1_500_000;
    localparam int CAPTURE_DELAY_NS = 1_000_000;
    localparam int INITIAL_DELAY_CYC = (INITIAL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BOOT_HOLD_CYC = (BOOT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VALIDATE_CYC = (VALIDATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GOOD_FOUR_CYC = (GOOD_DELAY_FOUR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GOOD_THREE_CYC = (GOOD_DELAY_THREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAPTURE_CYC = (CAPTURE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // stepping rates
    localparam int FIXED_STEP_HZ = 330_000;
    localparam int FIXED_STEP_CYC = CLK_HZ / FIXED_STEP_HZ;
    localparam int STEP_KOHM_DIV = 25;
    localparam int NS_PER_US = 1000;
    localparam int KOHM_W = 10;
    localparam int STEP_W = 16;
    localparam int CNT_W = 20;
    // reference levels in 6.25 mV steps
    localparam int STEP_UV = 6250;
    localparam int BOOT_LEVEL_UV = 1_100_000;
    localparam logic [CODE_W-1:0] BOOT_LEVEL = CODE_W'(BOOT_LEVEL_UV / STEP_UV);
    localparam logic [CODE_W-1:0] LEVEL_ZERO = 8'h00;
    // phase counts that use the second and third driver supplies
    localparam logic [1:0] PHASES_TWO = 2'h2;
    localparam logic [1:0] PHASES_THREE = 2'h3;

    typedef enum logic [3:0] {
        ST_SHUTDOWN, ST_INIT_DELAY, ST_RAMP_BOOT, ST_BOOT_HOLD, ST_CODE_WAIT,
        ST_CAPTURE_DELAY, ST_RAMP_FINAL, ST_GOOD_WAIT, ST_RUNNING
    } seq_state_t;

    // step period in clock cycles for the resistor-set oscillator
    function automatic logic [STEP_W-1:0] step_period(input logic [KOHM_W-1:0] kohm,
                                                       input logic four);
        if (!four || kohm == '0) begin
            step_period = STEP_W'(FIXED_STEP_CYC);
        end else begin
            step_period = STEP_W'((int'(kohm) * NS_PER_US) / (STEP_KOHM_DIV * CLK_PERIOD_NS));
        end
    endfunction : step_period
endpackage : startup_pkg

// ===== hw/code_qualifier.sv
// voltage-code qualifier: samples at the slow tick, accepts after equal readings
module code_qualifier
    import startup_pkg::*;
#(
    parameter int W = CODE_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // synchronised code pins
    input wire logic [W-1:0] code_in,
    // accepted code
    output logic [W-1:0] code_r,
    output logic valid_r
);
    logic [STEP_W-1:0] div_r, div_nxt;
    logic [W-1:0] last_r, last_nxt, code_nxt;
    logic [1:0] match_r, match_nxt;
    logic valid_nxt;

    // slow sample tick and agreement counting
    always_comb begin
        div_nxt = div_r - 1'b1;
        last_nxt = last_r;
        match_nxt = match_r;
        code_nxt = code_r;
        valid_nxt = valid_r;
        if (div_r == '0) begin
            div_nxt = STEP_W'(SAMPLE_CYC - 1);
            last_nxt = code_in;
            if (code_in != last_r) begin
                match_nxt = 2'h0;
            end else if (match_r != 2'(CODE_READS - 1)) begin
                match_nxt = match_r + 2'h1;
                if (match_r == 2'(CODE_READS - 2)) begin
                    code_nxt = code_in;
                    valid_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_r <= '0;
            last_r <= '0;
            match_r <= 2'h0;
            code_r <= '0;
            valid_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            last_r <= last_nxt;
            match_r <= match_nxt;
            code_r <= code_nxt;
            valid_r <= valid_nxt;
        end
    end

    // a code changes only after a run of agreeing samples
    property p_code_accept;
        @(posedge ref_clk) disable iff (!rst_b)
        $changed(code_r) |-> $past(match_r) == 2'(CODE_READS - 2);
    endproperty
    a_code_accept: assert property (p_code_accept) else $error("code accepted early");
endmodule : code_qualifier

// ===== hw/startup_sequencer.sv
// start-up qualification and soft-start sequencer for a multiphase buck controller
//
// Contract
// - pwm outputs high impedance in shutdown
// - stay shut until bias supply reset clears
// - stay shut until main enable comparator high
// - stay shut until fourth-phase enable high
// - need driver supplies; two/three phases need more
// - soft-start begins at once when qualified
// - five-bit three-period: all-ones code blocks start
// - four-period: initial fixed delay before ramping
// - first ramp climbs to boot level
// - hold boot level fixed time plus validation
// - code validation takes at least 500 ns
// - sample code, then ramp to coded level
// - four-period ramps move one step per tick
// - step period equals kilohms over 25 microseconds
// - grounded rate pin gives 330 kHz stepping
// - four-period power-good 440 us after final
// - three-period captures code then waits fixed delay
// - three-period ramps zero to code at 330 kHz
// - three-period power-good 1.5 ms after final
// - drivers off while feedback above reference
// - drivers enabled at end of soft-start anyway
// - power-good low in shutdown and soft-start
// - code accepted after three equal slow samples
module startup_sequencer
    import startup_pkg::*;
#(
    parameter int INIT_DELAY_CYCLES = INITIAL_DELAY_CYC,
    parameter int BOOT_HOLD_CYCLES = BOOT_HOLD_CYC,
    parameter int GOOD_FOUR_CYCLES = GOOD_FOUR_CYC,
    parameter int GOOD_THREE_CYCLES = GOOD_THREE_CYC,
    parameter int CAPTURE_CYCLES = CAPTURE_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // supply and enable comparators
    input wire logic core_bias_ok,
    input wire logic main_enable,
    input wire logic fourth_phase_enable,
    input wire logic driver_supply_first,
    input wire logic driver_supply_second,
    input wire logic driver_supply_third,
    // configuration straps
    input wire logic four_period_mode,
    input wire logic five_bit_mode,
    input wire logic [1:0] phase_count,
    input wire logic [KOHM_W-1:0] ramp_kohm,
    // processor code pins and feedback comparator
    input wire logic [CODE_W-1:0] voltage_code,
    input wire logic feedback_node_above_ref,
    // outputs
    output logic pwm_drive_en_r,
    output logic drivers_enable_r,
    output logic [CODE_W-1:0] reference_level_r,
    output logic power_good_out_r,
    output logic soft_start_active_r
);
    localparam int SYNC_W = 11 + CODE_W + KOHM_W;

    if (INIT_DELAY_CYCLES < 1 || INIT_DELAY_CYCLES >= 2**CNT_W ||
        GOOD_THREE_CYCLES < 1 || GOOD_THREE_CYCLES >= 2**CNT_W ||
        GOOD_FOUR_CYCLES < 1 || GOOD_FOUR_CYCLES >= 2**CNT_W ||
        CAPTURE_CYCLES < 1 || CAPTURE_CYCLES >= 2**CNT_W ||
        BOOT_HOLD_CYCLES < 1 || BOOT_HOLD_CYCLES >= 2**CNT_W) begin : g_bad_count
        $error("delay count out of counter range");
    end

    logic [SYNC_W-1:0] meta_r, sync_r;
    logic bias_s, en_s, ph4_s, drv1_s, drv2_s, drv3_s, fb_above_s, four_s, five_s;
    logic [1:0] phases_s;
    logic [KOHM_W-1:0] kohm_s;
    logic [CODE_W-1:0] code_s, code_q;
    logic code_valid;
    logic supplies_ok, start_ok, tick;

    seq_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [STEP_W-1:0] step_r, step_nxt;
    logic [CODE_W-1:0] target_r, target_nxt, ref_nxt;
    logic mode_four_r, mode_four_nxt;
    logic drv_nxt, pg_nxt, pwm_nxt, ss_nxt;

    // every pin passes two flops; the first rank feeds only the second
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= {core_bias_ok, main_enable, fourth_phase_enable, driver_supply_first,
                       driver_supply_second, driver_supply_third, feedback_node_above_ref,
                       four_period_mode, five_bit_mode, phase_count, ramp_kohm, voltage_code};
            sync_r <= meta_r;
        end
    end

    assign {bias_s, en_s, ph4_s, drv1_s, drv2_s, drv3_s, fb_above_s, four_s, five_s,
            phases_s, kohm_s, code_s} = sync_r;

    code_qualifier #(.W(CODE_W)) u_code (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .code_in(code_s),
        .code_r(code_q),
        .valid_r(code_valid)
    );

    // supplies and enables; losing any required one (drv2_s and drv3_s only with two or three phases) sends the sequence back to shutdown
    always_comb begin
        supplies_ok = bias_s && en_s && ph4_s && drv1_s;
        if (phases_s == PHASES_TWO || phases_s == PHASES_THREE) begin
            supplies_ok = supplies_ok && drv2_s && drv3_s;
        end
        // a five-bit all-ones code means no load; wait for a qualified other code
        start_ok = supplies_ok;
        if (!four_s && five_s) begin
            start_ok = supplies_ok && code_valid &&
                       code_q[CODE_FIVE_W-1:0] != '1;
        end
    end

    // ramp tick: the oscillator only runs while a ramp is in progress
    assign tick = (step_r == '0);

    // sequencer next state, counters and reference
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        step_nxt = step_r;
        ref_nxt = reference_level_r;
        target_nxt = target_r;
        mode_four_nxt = mode_four_r;
        drv_nxt = drivers_enable_r;
        pg_nxt = 1'b0;
        if (state_r == ST_RAMP_BOOT || state_r == ST_RAMP_FINAL) begin
            step_nxt = tick ? step_period(kohm_s, mode_four_r) - 1'b1
                            : step_r - 1'b1;
        end
        unique case (state_r)
            ST_SHUTDOWN: begin
                ref_nxt = LEVEL_ZERO;
                drv_nxt = 1'b0;
                if (start_ok) begin
                    mode_four_nxt = four_s;
                    if (four_s) begin
                        state_nxt = ST_INIT_DELAY;
                        cnt_nxt = CNT_W'(INIT_DELAY_CYCLES - 1);
                    end else begin
                        state_nxt = ST_CAPTURE_DELAY;
                        target_nxt = code_q;
                        cnt_nxt = CNT_W'(CAPTURE_CYCLES - 1);
                    end
                end
            end
            ST_INIT_DELAY: begin
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_r == '0) begin
                    state_nxt = ST_RAMP_BOOT;
                    target_nxt = BOOT_LEVEL;
                    step_nxt = step_period(kohm_s, mode_four_r) - 1'b1;
                end
            end
            ST_RAMP_BOOT, ST_RAMP_FINAL: begin
                if (reference_level_r == target_r) begin
                    if (state_r == ST_RAMP_BOOT) begin
                        state_nxt = ST_BOOT_HOLD;
                        cnt_nxt = CNT_W'(BOOT_HOLD_CYCLES - 1);
                    end else begin
                        state_nxt = ST_GOOD_WAIT;
                        drv_nxt = 1'b1;
                        cnt_nxt = mode_four_r ? CNT_W'(GOOD_FOUR_CYCLES - 1)
                                              : CNT_W'(GOOD_THREE_CYCLES - 1);
                    end
                end else if (tick) begin
                    // one 6.25 mV step per tick, either direction
                    ref_nxt = (reference_level_r < target_r) ? reference_level_r + 1'b1
                                                             : reference_level_r - 1'b1;
                end
            end
            ST_BOOT_HOLD: begin
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_r == '0) begin
                    state_nxt = ST_CODE_WAIT;
                    cnt_nxt = CNT_W'(VALIDATE_CYC - 1);
                end
            end
            ST_CODE_WAIT: begin
                // the code must read valid for the whole validation window
                if (!code_valid) begin
                    cnt_nxt = CNT_W'(VALIDATE_CYC - 1);
                end else if (cnt_r == '0) begin
                    state_nxt = ST_RAMP_FINAL;
                    target_nxt = code_q;
                    step_nxt = step_period(kohm_s, mode_four_r) - 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ST_CAPTURE_DELAY: begin
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_r == '0) begin
                    state_nxt = ST_RAMP_FINAL;
                    step_nxt = STEP_W'(FIXED_STEP_CYC - 1);
                end
            end
            ST_GOOD_WAIT: begin
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_r == '0) begin
                    state_nxt = ST_RUNNING;
                    pg_nxt = 1'b1;
                end
            end
            ST_RUNNING: begin
                pg_nxt = 1'b1;
            end
        endcase
        // pre-biased output: drivers wait until the reference passes feedback
        if (state_r != ST_SHUTDOWN && !fb_above_s) begin
            drv_nxt = 1'b1;
        end
        if (state_r != ST_SHUTDOWN && !supplies_ok) begin
            state_nxt = ST_SHUTDOWN;
            ref_nxt = LEVEL_ZERO;
            drv_nxt = 1'b0;
            pg_nxt = 1'b0;
        end
        pwm_nxt = (state_nxt != ST_SHUTDOWN);
        ss_nxt = (state_nxt != ST_SHUTDOWN && state_nxt != ST_RUNNING);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_SHUTDOWN;
            cnt_r <= '0;
            step_r <= '0;
            target_r <= LEVEL_ZERO;
            mode_four_r <= 1'b0;
            reference_level_r <= LEVEL_ZERO;
            drivers_enable_r <= 1'b0;
            power_good_out_r <= 1'b0;
            pwm_drive_en_r <= 1'b0;
            soft_start_active_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            step_r <= step_nxt;
            target_r <= target_nxt;
            mode_four_r <= mode_four_nxt;
            reference_level_r <= ref_nxt;
            drivers_enable_r <= drv_nxt;
            power_good_out_r <= pg_nxt;
            pwm_drive_en_r <= pwm_nxt;
            soft_start_active_r <= ss_nxt;
        end
    end

    // checks
    sequence s_ramp_move;
        $changed(reference_level_r) && $past(state_r) != ST_SHUTDOWN && state_r != ST_SHUTDOWN;
    endsequence
    property p_pwm_hiz;
        @(posedge ref_clk) disable iff (!rst_b) state_r == ST_SHUTDOWN |-> !pwm_drive_en_r;
    endproperty
    a_pwm_hiz: assert property (p_pwm_hiz) else $error("pwm driven in shutdown");
    property p_bias_hold;
        @(posedge ref_clk) disable iff (!rst_b) !bias_s |=> state_r == ST_SHUTDOWN;
    endproperty
    a_bias_hold: assert property (p_bias_hold) else $error("left shutdown without bias");
    property p_en_hold;
        @(posedge ref_clk) disable iff (!rst_b) !en_s |=> state_r == ST_SHUTDOWN;
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("left shutdown without enable");
    property p_ph4_hold;
        @(posedge ref_clk) disable iff (!rst_b) !ph4_s |=> state_r == ST_SHUTDOWN;
    endproperty
    a_ph4_hold: assert property (p_ph4_hold) else $error("left shutdown without ph4");
    property p_start_now;
        @(posedge ref_clk) disable iff (!rst_b)
        state_r == ST_SHUTDOWN && start_ok |=> state_r != ST_SHUTDOWN;
    endproperty
    a_start_now: assert property (p_start_now) else $error("start delayed");
    property p_no_load;
        @(posedge ref_clk) disable iff (!rst_b)
        state_r == ST_SHUTDOWN && !four_s && five_s && code_q[CODE_FIVE_W-1:0] == '1
        |=> state_r == ST_SHUTDOWN;
    endproperty
    a_no_load: assert property (p_no_load) else $error("started on no-load code");
    property p_step_one;
        @(posedge ref_clk) disable iff (!rst_b)
        s_ramp_move |-> (reference_level_r == $past(reference_level_r) + 1'b1) ||
                        (reference_level_r == $past(reference_level_r) - 1'b1);
    endproperty
    a_step_one: assert property (p_step_one) else $error("reference jumped");
    property p_good_low;
        @(posedge ref_clk) disable iff (!rst_b) power_good_out_r |-> state_r == ST_RUNNING;
    endproperty
    a_good_low: assert property (p_good_low) else $error("power good early");
    property p_drv_end;
        @(posedge ref_clk) disable iff (!rst_b)
        state_r == ST_RAMP_FINAL ##1 state_r == ST_GOOD_WAIT |-> drivers_enable_r;
    endproperty
    a_drv_end: assert property (p_drv_end) else $error("drivers off after soft-start");
    property p_init_flat;
        @(posedge ref_clk) disable iff (!rst_b)
        state_r == ST_INIT_DELAY |-> reference_level_r == LEVEL_ZERO;
    endproperty
    a_init_flat: assert property (p_init_flat) else $error("ramp during delay");
    // a one-cycle glitch may restart at once, so everything is checked on the very next edge
    property p_drop;
        @(posedge ref_clk) disable iff (!rst_b)
        state_r != ST_SHUTDOWN && !supplies_ok |=> state_r == ST_SHUTDOWN && !pwm_drive_en_r &&
            !power_good_out_r && reference_level_r == LEVEL_ZERO;
    endproperty
    a_drop: assert property (p_drop) else $error("no restart on lost supply");
endmodule : startup_sequencer

// ===== verification/code_pins_model.sv
// partner model: processor code pins and the output-voltage feedback comparator
module code_pins_model
    import startup_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // wanted code and pre-charged output level, in reference steps
    input wire logic [CODE_W-1:0] code_set,
    input wire logic [CODE_W:0] prebias_level,
    input wire logic [CODE_W-1:0] reference_level_r,
    // pins toward the sequencer
    output logic [CODE_W-1:0] voltage_code,
    output logic feedback_node_above_ref
);
    timeunit 1ns;
    timeprecision 1ps;
    initial voltage_code = '0;

    // pins settle one bit per cycle, so the qualifier sees skewed codes in between
    always @(posedge ref_clk) begin
        logic [CODE_W-1:0] diff;
        diff = voltage_code ^ code_set;
        voltage_code <= voltage_code ^ (diff & (~diff + 1'b1));
    end

    // output held above the reference until the ramp passes the pre-charge
    assign feedback_node_above_ref = ({1'b0, reference_level_r} < prebias_level);
endmodule : code_pins_model

// ===== verification/startup_softstart_sequencer_tb.sv
// self-checking bench for the start-up sequencer with a stepwise reference model
module startup_softstart_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import startup_pkg::*;
    localparam int DLY = 20;
    logic ref_clk, rst_b, core_bias_ok, main_enable, fourth_phase_enable;
    logic driver_supply_first, driver_supply_second, driver_supply_third;
    logic four_period_mode, five_bit_mode, feedback_node_above_ref;
    logic [1:0] phase_count;
    logic [KOHM_W-1:0] ramp_kohm;
    logic [CODE_W-1:0] voltage_code, code_set, reference_level_r;
    logic [CODE_W:0] prebias_level;
    logic pwm_drive_en_r, drivers_enable_r, power_good_out_r, soft_start_active_r;
    int n_errors, total_checks;
    logic [31:0] lfsr_r;

    // short delay counts keep the run within budget
    startup_sequencer #(.INIT_DELAY_CYCLES(DLY), .BOOT_HOLD_CYCLES(DLY),
        .GOOD_FOUR_CYCLES(DLY), .GOOD_THREE_CYCLES(DLY), .CAPTURE_CYCLES(DLY)
    ) startup_sequencer_i (.ref_clk(ref_clk), .rst_b(rst_b), .core_bias_ok(core_bias_ok),
        .main_enable(main_enable), .fourth_phase_enable(fourth_phase_enable),
        .driver_supply_first(driver_supply_first), .driver_supply_second(driver_supply_second),
        .driver_supply_third(driver_supply_third), .four_period_mode(four_period_mode),
        .five_bit_mode(five_bit_mode), .phase_count(phase_count), .ramp_kohm(ramp_kohm),
        .voltage_code(voltage_code), .feedback_node_above_ref(feedback_node_above_ref),
        .pwm_drive_en_r(pwm_drive_en_r), .drivers_enable_r(drivers_enable_r),
        .reference_level_r(reference_level_r), .power_good_out_r(power_good_out_r),
        .soft_start_active_r(soft_start_active_r));

    code_pins_model code_pins_model_i (.ref_clk(ref_clk), .code_set(code_set),
        .prebias_level(prebias_level), .reference_level_r(reference_level_r),
        .voltage_code(voltage_code), .feedback_node_above_ref(feedback_node_above_ref));

    // 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] lfsr_next();
        lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        return lfsr_r;
    endfunction : lfsr_next

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    // bias, enable, fourth-phase enable and the three driver supply flags
    task automatic cond(input logic [5:0] v);
        {core_bias_ok, main_enable, fourth_phase_enable, driver_supply_first,
            driver_supply_second, driver_supply_third} <= v;
    endtask : cond

    task automatic settle(input int four, input int kohm, input int code, input int pre);
        @(posedge ref_clk);
        cond(6'h00);
        four_period_mode <= 1'(four);
        ramp_kohm <= KOHM_W'(kohm);
        code_set <= CODE_W'(code);
        prebias_level <= 9'(pre);
        repeat (400) @(posedge ref_clk);
        cond(6'h3F);
    endtask : settle

    // model: reference walks one step per period toward the code, via boot level in four-period mode
    task automatic run_seq(input int four, input int kohm, input int code, input int pre);
        int sp, lvl, tgt, last, mark, gap, reached, done;
        settle(four, kohm, code, pre);
        sp = (four != 0 && kohm != 0) ? kohm * 8 : 606;
        tgt = (four != 0) ? int'(BOOT_LEVEL) : code;
        lvl = 0;
        last = -1;
        mark = 0;
        gap = DLY;
        reached = -1;
        done = 0;
        for (int c = 0; c < 60000 && done == 0; c++) begin
            @(posedge ref_clk);
            #1;
            if (reached < 0) begin
                chk(power_good_out_r, 0);
            end else if (power_good_out_r === 1'b1) begin
                chk(c - reached, DLY + 1);
                chk(drivers_enable_r, 1);
                done = 1;
            end
            if (reference_level_r !== CODE_W'(lvl)) begin
                lvl = (lvl > tgt) ? lvl - 1 : lvl + 1;
                chk(reference_level_r, lvl);
                if (last >= 0) begin
                    chk(c - last, sp);
                end else begin
                    chk(c - mark >= gap, 1);
                end
                last = c;
                if (pre > 0 && lvl + 3 < pre) begin
                    chk(drivers_enable_r, 0);
                end else if (lvl > pre + 3) begin
                    chk(drivers_enable_r, 1);
                end
                if (lvl == tgt && four != 0 && tgt == int'(BOOT_LEVEL)) begin
                    tgt = code;
                    mark = c;
                    gap = DLY + VALIDATE_CYC;
                    last = -1;
                end else if (lvl == tgt) begin
                    reached = c;
                end
            end
        end
        if (done == 0) begin
            n_errors++;
            final_report();
        end
    endtask : run_seq

    task automatic wait_ref(input int lvl);
        int c;
        c = 0;
        while (reference_level_r !== CODE_W'(lvl) && c < 3000) begin
            @(posedge ref_clk);
            #1;
            c++;
        end
        chk(c < 3000, 1);
        // a stuck ramp ends the run here rather than cascading into later checks
        if (c >= 3000) begin
            final_report();
        end
    endtask : wait_ref

    initial begin
        int t0;
        {core_bias_ok, main_enable, fourth_phase_enable} = '0;
        {driver_supply_first, driver_supply_second, driver_supply_third} = '0;
        {four_period_mode, five_bit_mode, phase_count, ramp_kohm} = '0;
        code_set = '0;
        prebias_level = '0;
        n_errors = 0;
        total_checks = 0;
        lfsr_r = 32'd32488;
        rst_b = 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        phase_count <= 2'h3;
        four_period_mode <= 1'b1;
        // each missing condition alone keeps the pwm outputs released
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            cond(6'h3F ^ (6'h20 >> i));
            phase_count <= 2'h2 + 2'(i % 2);
            repeat (60) @(posedge ref_clk);
            #1;
            chk(pwm_drive_en_r, 0);
            chk({soft_start_active_r, power_good_out_r}, 0);
        end
        // one phase needs only the first driver supply
        @(posedge ref_clk);
        phase_count <= 2'h1;
        cond(6'h3C);
        repeat (10) @(posedge ref_clk);
        #1;
        chk(pwm_drive_en_r, 1);
        chk(soft_start_active_r, 1);
        run_seq(1, 2, 177 + lfsr_next() % 60, 20 + lfsr_next() % 100);
        run_seq(1, 3, 150, 0);
        // grounded rate pin, then a dropped enable mid-ramp restarts from zero
        settle(1, 0, 200, 0);
        wait_ref(1);
        t0 = $time / CLK_PERIOD_NS;
        wait_ref(2);
        chk($time / CLK_PERIOD_NS - t0, FIXED_STEP_CYC);
        @(posedge ref_clk);
        main_enable <= 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
        chk({pwm_drive_en_r, drivers_enable_r, power_good_out_r}, 0);
        chk(reference_level_r, 0);
        @(posedge ref_clk);
        main_enable <= 1'b1;
        repeat (DLY / 2) @(posedge ref_clk);
        #1;
        chk({soft_start_active_r, reference_level_r}, 9'h100);
        // five-bit three-period: the no-load code blocks start
        @(posedge ref_clk);
        five_bit_mode <= 1'b1;
        settle(0, 0, 8'h3F, 0);
        repeat (600) @(posedge ref_clk);
        #1;
        chk(soft_start_active_r, 0);
        run_seq(0, 0, 6, 9'h100);
        // six-bit three-period starts at once on code 8'h1F, all ones in its low five bits
        @(posedge ref_clk);
        five_bit_mode <= 1'b0;
        run_seq(0, 0, 8'h1F, 4);
        final_report();
    end
endmodule : startup_softstart_sequencer_tb
